// ### hdl/rsc_regs.sv
// Receiver path, receiver analog, host serial speed and oscillator trim registers.
// Assumes an AXI4-Lite master on clk and front end pins sampled through synchronisers.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module rsc_regs (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   // AXI4-Lite write address channel.
   input  wire logic [9:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [9:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Settings driven to the analog receiver.
   output rsc_pkg::rsc_rx_cfg_t       rx_cfg,
   output logic [7:0]                 slow_osc_trim_value,
   // Candidate inputs of the signal processing unit, from pins.
   input  wire logic                  analog_rx_in,
   input  wire logic                  envelope_in,
   input  wire logic                  generic_in,
   output logic                       signal_proc_in,
   // Signal strengths from the converter, on clk.
   input  wire logic [7:0]            main_strength,
   input  wire logic [7:0]            secondary_strength,
   output logic                       collision,
   // Host serial bit clock towards the UART datapath.
   input  wire logic                  char_start,
   output logic                       char_busy,
   output logic                       bit_tick,
   output logic [3:0]                 bit_index
);

   // Configuration registers.
   logic [7:0]  path_q,   path_d;     // Receiver path select.
   logic [7:0]  ana_q,    ana_d;      // Receiver analog setup.
   logic [7:0]  speed_q,  speed_d;    // Host serial bit rate.
   logic [7:0]  trim_q,   trim_d;     // Slow oscillator trim.

   // Write channel state.
   logic        aw_held_q, aw_held_d; // Write address captured.
   logic [9:0]  awaddr_q,  awaddr_d;  // Captured write address.
   logic        w_held_q,  w_held_d;  // Write data captured.
   logic [7:0]  wdata_q,   wdata_d;   // Captured low data byte.
   logic        wstrb_q,   wstrb_d;   // Captured low byte lane enable.
   logic        bvalid_q,  bvalid_d;  // Write response pending.
   logic [1:0]  bresp_q,   bresp_d;   // Write response code.
   logic        commit;               // Both halves present, write now.

   // Read channel state.
   logic        rvalid_q,  rvalid_d;  // Read data pending.
   logic [31:0] rdata_q,   rdata_d;   // Read data word.
   logic [1:0]  rresp_q,   rresp_d;   // Read response code.

   // Front end pin synchronisers and derived outputs.
   logic [2:0]  sync1_q;              // First stage, read by second stage only.
   logic [2:0]  sync2_q;              // Second stage, safe to use.
   logic        sig_q,     sig_d;     // Routed signal processing input.
   logic        coll_q,    coll_d;    // Collision flag.

   // Channel readiness: one write and one read at a time.
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign commit        = aw_held_q && w_held_q && !bvalid_q;

   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // Fields of the two receiver registers towards the analog side, in one driver.
   assign rx_cfg = '{
      quasi_diff:              path_q[7],
      low_power_card_detect:   path_q[6],
      signal_source_select:    path_q[5:4],
      collision_threshold:     path_q[1:0],
      factory_midvoltage_trim: ana_q[7:6],
      hpcf_select:             ana_q[3:2],
      gain_select:             ana_q[1:0]
   };
   assign slow_osc_trim_value            = trim_q;
   assign signal_proc_in                 = sig_q;
   assign collision                      = coll_q;

   // Read decode of one register word; unmapped addresses give no data.
   function automatic logic [7:0] read_mux(input logic [9:0] a);
      unique case (a)
         rsc_pkg::ADDR_PATH:  read_mux = path_q;
         rsc_pkg::ADDR_ANA:   read_mux = ana_q;
         rsc_pkg::ADDR_SPEED: read_mux = speed_q;
         rsc_pkg::ADDR_TRIM:  read_mux = trim_q;
         default:             read_mux = 8'h00;
      endcase
   endfunction

   // True when the address selects one of the four registers.
   function automatic logic mapped(input logic [9:0] a);
      mapped = (a == rsc_pkg::ADDR_PATH) || (a == rsc_pkg::ADDR_ANA) ||
               (a == rsc_pkg::ADDR_SPEED) || (a == rsc_pkg::ADDR_TRIM);
   endfunction

   // Next values of the write channel and the register contents.
   always_comb begin
      aw_held_d = aw_held_q;
      awaddr_d  = awaddr_q;
      w_held_d  = w_held_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      path_d    = path_q;
      ana_d     = ana_q;
      speed_d   = speed_q;
      trim_d    = trim_q;
      // Address and data are taken independently, in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_d = 1'b1;
         wdata_d  = s_axi_wdata[7:0];
         wstrb_d  = s_axi_wstrb[0];
      end
      // With both halves present the write is answered; the register is updated only if the low lane is enabled.
      if (commit) begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = mapped(awaddr_q) ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
         if (wstrb_q) begin
            unique case (awaddr_q)
               rsc_pkg::ADDR_PATH:  path_d  = wdata_q & rsc_pkg::PATH_MASK;
               rsc_pkg::ADDR_ANA:   ana_d   = wdata_q & rsc_pkg::ANA_MASK;
               rsc_pkg::ADDR_SPEED: speed_d = wdata_q;
               rsc_pkg::ADDR_TRIM:  trim_d  = wdata_q;
               default:             path_d  = path_q;
            endcase
         end
      end
      // The response leaves once the master takes it.
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // Write channel and register storage.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= 10'h000;
         w_held_q  <= 1'b0;
         wdata_q   <= 8'h00;
         wstrb_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= rsc_pkg::RESP_OKAY;
         path_q    <= rsc_pkg::PATH_RESET;
         ana_q     <= rsc_pkg::ANA_RESET;
         speed_q   <= rsc_pkg::SPEED_RESET;
         trim_q    <= rsc_pkg::TRIM_RESET;
      end else begin
         aw_held_q <= aw_held_d;
         awaddr_q  <= awaddr_d;
         w_held_q  <= w_held_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         path_q    <= path_d;
         ana_q     <= ana_d;
         speed_q   <= speed_d;
         trim_q    <= trim_d;
      end
   end

   // Next values of the read channel; data are latched at the address handshake.
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rdata_d  = {24'h00_0000, read_mux(s_axi_araddr)};
         rresp_d  = mapped(s_axi_araddr) ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   // Read channel registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= rsc_pkg::RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
      end
   end

   // Two-stage synchroniser of the three pin inputs.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 3'b000;
         sync2_q <= 3'b000;
      end else begin
         sync1_q <= {generic_in, envelope_in, analog_rx_in};
         sync2_q <= sync1_q;
      end
   end

   // Source routing and collision decision from the current settings.
   always_comb begin
      sig_d  = 1'b0;
      coll_d = 1'b0;
      unique case (path_q[5:4])
         rsc_pkg::SRC_IDLE:     sig_d = 1'b0;
         rsc_pkg::SRC_ANALOG:   sig_d = sync2_q[0];
         rsc_pkg::SRC_ENVELOPE: sig_d = sync2_q[1];
         rsc_pkg::SRC_GENERIC:  sig_d = sync2_q[2];
      endcase
      unique case (path_q[1:0])
         rsc_pkg::COLL_EIGHTH:  coll_d = secondary_strength >= (main_strength >> 3);
         rsc_pkg::COLL_QUARTER: coll_d = secondary_strength >= (main_strength >> 2);
         rsc_pkg::COLL_HALF:    coll_d = secondary_strength >= (main_strength >> 1);
         rsc_pkg::COLL_OFF:     coll_d = 1'b0;
      endcase
   end

   // Routed signal and collision flag registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sig_q  <= 1'b0;
         coll_q <= 1'b0;
      end else begin
         sig_q  <= sig_d;
         coll_q <= coll_d;
      end
   end

   // Bit clock generator, fed from the serial speed register.
   rsc_baud_gen i_rsc_baud_gen (
      .clk        (clk),
      .arst_n     (arst_n),
      .speed      (rsc_pkg::rsc_speed_t'(speed_q)),
      .char_start (char_start),
      .char_busy  (char_busy),
      .bit_tick   (bit_tick),
      .bit_index  (bit_index)
   );

   AST_PATH_RSVD: assert property (@(posedge clk) disable iff (!arst_n)
      commit && wstrb_q && (awaddr_q == rsc_pkg::ADDR_PATH)
      |=> (path_q[3:2] == 2'b00) && (path_q[7:4] == $past(wdata_q[7:4])))
      else $error("Receiver path write stored wrong bits.");

   AST_ANA_RSVD: assert property (@(posedge clk) disable iff (!arst_n)
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == rsc_pkg::ADDR_ANA)
      |=> s_axi_rvalid && (s_axi_rdata[5:4] == 2'b00))
      else $error("Reserved analog bits did not read as zero.");

   // idle source gives a quiet input.
   AST_SRC_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
      (path_q[5:4] == rsc_pkg::SRC_IDLE) |=> !signal_proc_in)
      else $error("Signal input active while source is idle.");

   AST_COLL_OFF: assert property (@(posedge clk) disable iff (!arst_n)
      (path_q[1:0] == rsc_pkg::COLL_OFF) |=> !collision)
      else $error("Collision flagged while detection is off.");

   AST_COLL_HALF: assert property (@(posedge clk) disable iff (!arst_n)
      (path_q[1:0] == rsc_pkg::COLL_HALF)
      |=> collision == ($past(secondary_strength) >= ($past(main_strength) >> 1)))
      else $error("Half strength collision decision wrong.");

   AST_GAIN_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      commit && wstrb_q && (awaddr_q == rsc_pkg::ADDR_ANA)
      |=> (rx_cfg.gain_select == $past(wdata_q[1:0])) && s_axi_bvalid)
      else $error("Gain select did not follow the analog write.");

   AST_TRIM_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      commit && wstrb_q && (awaddr_q == rsc_pkg::ADDR_TRIM)
      |=> slow_osc_trim_value == $past(wdata_q))
      else $error("Oscillator trim did not follow the write.");

   // speed keeps its code until written.
   AST_SPEED_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      !(commit && (awaddr_q == rsc_pkg::ADDR_SPEED)) |=> $stable(speed_q))
      else $error("Serial speed changed without a write.");

endmodule

// ### hdl/rsc_pkg.sv
// Constants, types and the divisor helper function of the receiver and serial configuration bank.
// Assumes a single 125 MHz clock and a bus slave that places each register in one word.
package rsc_pkg;

   // Register indices as printed; the byte address is four times the index.
   localparam logic [7:0] IDX_PATH  = 8'h38;
   localparam logic [7:0] IDX_ANA   = 8'h39;
   localparam logic [7:0] IDX_SPEED = 8'h3b;
   localparam logic [7:0] IDX_TRIM  = 8'h3c;

   // Byte addresses seen on the bus.
   localparam int unsigned ADDR_W   = 10;
   localparam logic [9:0] ADDR_PATH  = {IDX_PATH, 2'b00};
   localparam logic [9:0] ADDR_ANA   = {IDX_ANA, 2'b00};
   localparam logic [9:0] ADDR_SPEED = {IDX_SPEED, 2'b00};
   localparam logic [9:0] ADDR_TRIM  = {IDX_TRIM, 2'b00};

   // Writable bit masks; reserved bits are cleared by these.
   localparam logic [7:0] PATH_MASK = 8'hf3;
   localparam logic [7:0] ANA_MASK  = 8'hcf;

   // Reset values of the four registers.
   localparam logic [7:0] PATH_RESET  = 8'h00;
   localparam logic [7:0] ANA_RESET   = 8'h00;
   localparam logic [7:0] SPEED_RESET = 8'h7a;
   localparam logic [7:0] TRIM_RESET  = 8'h00;

   // Bus response codes.
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Rate figures in kHz: reference of the bit clock and the system clock.
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam logic [31:0] REF_KHZ       = 32'd27120;
   localparam logic [31:0] CLK_KHZ       = 32'(1000000000 / CLK_PERIOD_PS);
   localparam logic [12:0] MANT_OFFSET   = 13'd33;

   // Character framing: start, data and stop bits, no parity.
   localparam int unsigned START_BITS = 1;
   localparam int unsigned DATA_BITS  = 8;
   localparam int unsigned STOP_BITS  = 1;
   localparam logic [3:0]  CHAR_LAST  = 4'(START_BITS + DATA_BITS + STOP_BITS - 1);

   // Signal source codes of the signal processing input.
   localparam logic [1:0] SRC_IDLE     = 2'h0;
   localparam logic [1:0] SRC_ANALOG   = 2'h1;
   localparam logic [1:0] SRC_ENVELOPE = 2'h2;
   localparam logic [1:0] SRC_GENERIC  = 2'h3;

   // Collision threshold codes.
   localparam logic [1:0] COLL_EIGHTH  = 2'h0;
   localparam logic [1:0] COLL_QUARTER = 2'h1;
   localparam logic [1:0] COLL_HALF    = 2'h2;
   localparam logic [1:0] COLL_OFF     = 2'h3;

   // Receiver path and analog settings as driven to the front end.
   typedef struct packed {
      logic       quasi_diff;              // Single positive receive pin mode.
      logic       low_power_card_detect;   // Converter in card detection mode.
      logic [1:0] signal_source_select;    // Source of the signal processing.
      logic [1:0] collision_threshold;     // Collision strength code.
      logic [1:0] factory_midvoltage_trim; // Factory trim, kept at zero by software.
      logic [1:0] hpcf_select;             // High-pass corner of the baseband amplifier.
      logic [1:0] gain_select;             // Baseband gain, higher code is more gain.
   } rsc_rx_cfg_t;

   // Serial speed register split into its two fields.
   typedef struct packed {
      logic [2:0] baud_exponent;           // Power of two part.
      logic [4:0] baud_mantissa;           // Linear part.
   } rsc_speed_t;

   // Divisor of the reference for a speed setting, in reference periods.
   function automatic logic [12:0] divisor(input rsc_speed_t s);
      logic [12:0] base;
      base = 13'(s.baud_mantissa) + MANT_OFFSET;
      if (s.baud_exponent == 3'd0) begin
         divisor = 13'(s.baud_mantissa) + 13'd1;
      end else begin
         divisor = 13'(base << (s.baud_exponent - 3'd1));
      end
   endfunction

endpackage

// ### hdl/rsc_baud_gen.sv
// Bit clock generator of the host serial port, with character framing count.
// Assumes the UART datapath pulses char_start on the system clock and uses bit_tick.
`timescale 1ns/1ps
module rsc_baud_gen (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire rsc_pkg::rsc_speed_t speed,
   input  wire logic              char_start,
   output logic                   char_busy,
   output logic                   bit_tick,
   output logic [3:0]             bit_index
);

   // Character sequencing states.
   typedef enum logic {ST_IDLE, ST_RUN} rsc_baud_st_t;

   rsc_baud_st_t st_q,   st_d;    // Character state.
   logic [12:0]  div_q,  div_d;   // Divisor in force for this character.
   logic [31:0]  acc_q,  acc_d;   // Phase accumulator in kHz units.
   logic [3:0]   cnt_q,  cnt_d;   // Bit position within the character.
   logic         tick_q, tick_d;  // Registered bit strobe.
   logic [31:0]  thr;             // Accumulator threshold for one bit.
   logic [31:0]  sum;             // Accumulator plus one reference step.

   assign thr       = 32'(div_q) * rsc_pkg::CLK_KHZ;
   assign sum       = acc_q + rsc_pkg::REF_KHZ;
   assign char_busy = (st_q == ST_RUN);
   assign bit_tick  = tick_q;
   assign bit_index = cnt_q;

   // Next state: divisor follows software only while no character runs.
   always_comb begin
      st_d   = st_q;
      div_d  = div_q;
      acc_d  = acc_q;
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            div_d = rsc_pkg::divisor(speed);
            acc_d = 32'd0;
            cnt_d = 4'd0;
            if (char_start) begin
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (sum >= thr) begin
               acc_d  = sum - thr;
               tick_d = 1'b1;
               if (cnt_q == rsc_pkg::CHAR_LAST) begin
                  st_d  = ST_IDLE;
                  cnt_d = 4'd0;
               end else begin
                  cnt_d = cnt_q + 4'd1;
               end
            end else begin
               acc_d = sum;
            end
         end
      endcase
   end

   // State registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q   <= ST_IDLE;
         div_q  <= 13'd1;
         acc_q  <= 32'd0;
         cnt_q  <= 4'd0;
         tick_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         div_q  <= div_d;
         acc_q  <= acc_d;
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   AST_DIV_FROZEN: assert property (@(posedge clk) disable iff (!arst_n)
      (st_q == ST_RUN) && $past(st_q == ST_RUN) |-> $stable(div_q))
      else $error("Divisor changed inside a character.");

   AST_FRAME_LEN: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(char_busy) |-> bit_tick && ($past(cnt_q) == rsc_pkg::CHAR_LAST))
      else $error("Character did not end on its tenth bit.");

   AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!arst_n)
      bit_tick |=> !bit_tick [*3])
      else $error("Bit ticks closer than the reference allows.");

endmodule

// ### verif/rsc_regs_tb_top.sv
// Self-checking bench of the receiver and serial configuration bank.
// Assumes rsc_regs alone on one 125 MHz clock, reached over AXI4-Lite.
`timescale 1ns/1ps
module rsc_regs_tb_top;
   logic                 clk = 1'b0, arst_n = 1'b0;
   logic [9:0]           s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]          s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]           s_axi_wstrb = 4'h1;
   logic                 s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic                 s_axi_arvalid = 0, s_axi_rready = 0, char_start = 0;
   logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic                 s_axi_rvalid, signal_proc_in, collision, char_busy, bit_tick;
   logic [1:0]           s_axi_bresp, s_axi_rresp, rsp;
   logic                 analog_rx_in = 0, envelope_in = 0, generic_in = 0;
   logic [7:0]           main_strength = 8'h50, secondary_strength = 8'h14, slow_osc_trim_value;
   logic [3:0]           bit_index;
   logic [31:0]          rd;
   rsc_pkg::rsc_rx_cfg_t rx_cfg;
   int                   err_total = 0, n_compared = 0;

   // The bench clock toggles every half period of 8 ns.
   always #4 clk = ~clk;

   rsc_regs i_rsc_regs (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_cfg, .slow_osc_trim_value,
      .analog_rx_in, .envelope_in, .generic_in, .signal_proc_in, .main_strength,
      .secondary_strength, .collision, .char_start, .char_busy, .bit_tick, .bit_index);

   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Compares one value with its expectation and counts the result.
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Write: address and data offered together, each dropped when taken; settled values
   // are sampled at the falling edge and acted on at the next rising edge.
   task automatic axw(input logic [9:0] a, input logic [7:0] d);
      bit ta, tw, tb;
      @(posedge clk);
      s_axi_awaddr <= a; s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      for (int n = 0; n < 60; n++) begin
         @(negedge clk);
         ta = s_axi_awvalid && s_axi_awready; tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid; rsp = s_axi_bresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         if (tb) begin s_axi_bready <= 0; return; end
      end
      err_total++;
      end_sim();
   endtask

   // Read: address held until taken, rready held until the data are seen.
   task automatic axr(input logic [9:0] a);
      bit ta, tr;
      @(posedge clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      for (int n = 0; n < 60; n++) begin
         @(negedge clk);
         ta = s_axi_arvalid && s_axi_arready; tr = s_axi_rvalid;
         rd = s_axi_rdata; rsp = s_axi_rresp;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 0;
         if (tr) begin s_axi_rready <= 0; return; end
      end
      err_total++;
      end_sim();
   endtask

   // Speed reset value, reserved bits, field outputs, trim and an unmapped place.
   task automatic t_regs();
      axr(rsc_pkg::ADDR_SPEED); chk("speed reset", rd, 32'h0000_007a);
      axw(rsc_pkg::ADDR_PATH, 8'hff); axr(rsc_pkg::ADDR_PATH);
      chk("path rsvd", rd, 32'h0000_00f3);
      chk("quasi", rx_cfg.quasi_diff, 1);
      chk("low_power_card_detect", rx_cfg.low_power_card_detect, 1);
      // factory trim field always written as zero.
      axw(rsc_pkg::ADDR_ANA, 8'h3f); axr(rsc_pkg::ADDR_ANA);
      chk("ana rsvd", rd, 32'h0000_000f);
      chk("vmid", rx_cfg.factory_midvoltage_trim, 2'b00);
      axw(rsc_pkg::ADDR_ANA, 8'h09);
      chk("hpcf", rx_cfg.hpcf_select, 2);
      chk("gain", rx_cfg.gain_select, 1);
      axw(rsc_pkg::ADDR_TRIM, 8'ha5); axr(rsc_pkg::ADDR_TRIM);
      chk("trim rd", rd, 32'h0000_00a5);
      chk("trim resp", rsp, rsc_pkg::RESP_OKAY);
      chk("trim out", slow_osc_trim_value, 8'ha5);
      // A write with the low lane disabled stores nothing and is answered OKAY.
      s_axi_wstrb <= 4'h0;
      axw(rsc_pkg::ADDR_TRIM, 8'h3c);
      s_axi_wstrb <= 4'h1;
      chk("strb resp", rsp, rsc_pkg::RESP_OKAY);
      chk("strb off", slow_osc_trim_value, 8'ha5);
      axw(10'h000, 8'h11); chk("unmapped wr", rsp, rsc_pkg::RESP_SLVERR);
      axr(10'h000); chk("unmapped rd", rsp, rsc_pkg::RESP_SLVERR);
      chk("unmapped data", rd, 32'h0000_0000);
   endtask

   // Every source code and threshold code; only the chosen pin is high and
   // the secondary strength sits exactly at one quarter of the main one.
   task automatic t_route();
      for (int s = 0; s < 4; s++) begin
         axw(rsc_pkg::ADDR_PATH, {2'b00, 2'(s), 2'b00, 2'(s)});
         analog_rx_in <= (s == 1); envelope_in <= (s == 2); generic_in <= (s == 3);
         repeat (5) @(posedge clk);
         chk("src", rx_cfg.signal_source_select, s);
         chk("coll code", rx_cfg.collision_threshold, s);
         chk("route", signal_proc_in, (s != 0));
         chk("collision", collision, (s < 2));
      end
   endtask

   // Pulses char_start for one cycle, launched just after a rising edge.
   task automatic kick();
      @(posedge clk);
      char_start <= 1'b1;
      @(posedge clk);
      char_start <= 1'b0;
   endtask

   // Follows one running character: ten ticks, the bit index after each, and the
   // number of cycles until busy drops, which must lie strictly between lo and hi.
   task automatic char_len(input int lo, input int hi);
      int t, c, bad;
      t = 0;
      bad = 0;
      for (c = 0; c < 4000; c++) begin
         @(negedge clk);
         if (bit_tick) begin
            t++;
            bad += int'(bit_index !== 4'(t % 10));
         end
         if (!char_busy) break;
      end
      chk("ticks", t, 10);
      chk("index", bad, 0);
      chk("char time", (c > lo && c < hi), 1);
   endtask

   // A character at code 3Ah (about 271.9 cycles a bit) with 15h written while it
   // runs, then a character at 15h (about 101.4 cycles a bit).
   task automatic t_baud();
      // both codes stay at or below the rate ceiling.
      axw(rsc_pkg::ADDR_SPEED, 8'h3a);
      kick();
      axw(rsc_pkg::ADDR_SPEED, 8'h15);
      char_len(2700, 2730);
      kick();
      char_len(1000, 1030);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1;
      t_regs();
      t_route();
      t_baud();
      end_sim();
   end
endmodule
